// file: src/shrp_params.svh
`ifndef SHRP_PARAMS_SVH
`define SHRP_PARAMS_SVH
// ==========================================================
// record layout
`define SHRP_OXY_LEN        4'h9
`define SHRP_BP_LEN         4'hb
`define SHRP_BUF_BYTES      11
`define SHRP_CAL_DONE       8'h64
`define SHRP_REST_HR_LIMIT  16'h03b6
// ==========================================================
// command framing
`define SHRP_CMD_START      8'haa
`define SHRP_RSP_START      8'hab
`define SHRP_FAM_OUT_MODE   8'h10
`define SHRP_IDX_OUT_MODE   8'h00
`define SHRP_IDX_FIFO_THR   8'h01
`define SHRP_ST_OK          8'h00
`define SHRP_ST_BAD_CMD     8'h02
`define SHRP_ST_BAD_FRAME   8'h03
`define SHRP_MODE_RST       8'h00
`define SHRP_THR_RST        8'h00
`define SHRP_MODE_ALGO_BIT  1
`endif

// file: src/shrp_pkg.sv
package shrp_pkg;
  typedef enum logic [1:0] {
    SHRP_OXY_ADJUST,
    SHRP_OXY_COMPUTE,
    SHRP_OXY_SUCCESS,
    SHRP_OXY_TIMEOUT
  } shrp_oxy_state_t;

  typedef struct packed {
    logic [15:0]     ratio_x10;
    logic [7:0]      confidence;
    logic [15:0]     spo2_x10;
    logic [7:0]      progress;
    logic            low_signal_quality_flag;
    logic            motion_flag;
    shrp_oxy_state_t oxygen_algorithm_state;
  } shrp_oxy_rec_t;

  typedef struct packed {
    logic [2:0]  status;
    logic [7:0]  cal_progress;
    logic [15:0] heart_rate_x10;
    logic [7:0]  systolic;
    logic [7:0]  diastolic;
    logic [15:0] spo2_x10;
    logic [15:0] ratio_x10;
  } shrp_bp_rec_t;
endpackage : shrp_pkg

// file: src/shrp_record_packer.sv
// Functional notes
// - oxygen record: ratio, confidence, saturation first
// - then one-shot calculation progress byte
// - then low-signal flag, then motion flag
// - last oxygen byte: algorithm state code 0-3
// - pressure record starts with status code 0-6
// - second byte: calibration progress, 100 complete
// - then 2-byte heart rate, 0.1 bpm
// - systolic byte, valid once progress 100
// - diastolic byte, valid once progress 100
// - then 2-byte saturation, 0.1 percent
// - then 16-bit ratio, lsb 0.1
// - last byte: heart rate above 95 flag
// - output mode command answered 0xab 0x00
// - second mode command answered with status 0x00
`timescale 1ns/1ps
`include "shrp_params.svh"

module shrp_record_packer (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_clk_en,
  input  wire logic                   i_oxy_valid,
  input  wire shrp_pkg::shrp_oxy_rec_t i_oxy_rec,
  output logic                        o_oxy_ready,
  input  wire logic                   i_bp_valid,
  input  wire shrp_pkg::shrp_bp_rec_t  i_bp_rec,
  output logic                        o_bp_ready,
  output logic                        o_fifo_valid,
  output logic [7:0]                  o_fifo_data,
  input  wire logic                   i_fifo_ready,
  input  wire logic                   i_cmd_valid,
  input  wire logic [7:0]             i_cmd_byte,
  input  wire logic                   i_cmd_last,
  output logic                        o_cmd_ready,
  output logic                        o_rsp_valid,
  output logic [7:0]                  o_rsp_byte,
  input  wire logic                   i_rsp_ready,
  output logic [7:0]                  o_output_mode,
  output logic [7:0]                  o_fifo_threshold
);
  // ==========================================================
  // record packing
  localparam int BUF_W = `SHRP_BUF_BYTES * 8;

  logic [BUF_W-1:0] buf_q;
  logic [BUF_W-1:0] buf_d;
  logic [3:0]       left_q;
  logic [3:0]       left_d;

  wire idle      = (left_q == 4'h0);
  wire algo_on   = o_output_mode[`SHRP_MODE_ALGO_BIT];
  wire take_oxy  = idle && algo_on && i_oxy_valid;
  // oxygen has priority; pressure waits one record
  wire take_bp   = idle && algo_on && i_bp_valid && !i_oxy_valid;
  wire byte_out  = !idle && i_fifo_ready;

  // systolic and diastolic gated until calibration completes so the host never sees stale numbers
  wire       cal_done  = (i_bp_rec.cal_progress == `SHRP_CAL_DONE);
  wire [7:0] sys_byte  = cal_done ? i_bp_rec.systolic : 8'h00;
  wire [7:0] dia_byte  = cal_done ? i_bp_rec.diastolic : 8'h00;
  wire       elevated  = (i_bp_rec.heart_rate_x10 > `SHRP_REST_HR_LIMIT);

  wire [71:0] oxy_bytes = {i_oxy_rec.ratio_x10,
                           i_oxy_rec.confidence,
                           i_oxy_rec.spo2_x10,
                           i_oxy_rec.progress,
                           7'h00, i_oxy_rec.low_signal_quality_flag,
                           7'h00, i_oxy_rec.motion_flag,
                           6'h00, i_oxy_rec.oxygen_algorithm_state};

  wire [87:0] bp_bytes  = {5'h00, i_bp_rec.status,
                           i_bp_rec.cal_progress,
                           i_bp_rec.heart_rate_x10,
                           sys_byte,
                           dia_byte,
                           i_bp_rec.spo2_x10,
                           i_bp_rec.ratio_x10,
                           7'h00, elevated};

  assign o_oxy_ready  = idle && algo_on;
  assign o_bp_ready   = idle && algo_on && !i_oxy_valid;
  assign o_fifo_valid = !idle;
  assign o_fifo_data  = buf_q[BUF_W-1 -: 8];

  always_comb
  begin
    buf_d  = buf_q;
    left_d = left_q;
    if (take_oxy)
    begin
      buf_d  = {oxy_bytes, 16'h0000};
      left_d = `SHRP_OXY_LEN;
    end
    else if (take_bp)
    begin
      buf_d  = bp_bytes;
      left_d = `SHRP_BP_LEN;
    end
    else if (byte_out)
    begin
      buf_d  = {buf_q[BUF_W-9:0], 8'h00};
      left_d = left_q - 4'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      buf_q  <= '0;
      left_q <= 4'h0;
    end
    else if (i_clk_en)
    begin
      buf_q  <= buf_d;
      left_q <= left_d;
    end
  end

  // ==========================================================
  // command frames
  typedef enum logic [2:0] {
    SHRP_C_HDR,
    SHRP_C_FAM,
    SHRP_C_IDX,
    SHRP_C_DATA,
    SHRP_C_DRAIN,
    SHRP_C_RSP0,
    SHRP_C_RSP1
  } shrp_cmd_st_t;

  shrp_cmd_st_t cst_q;
  shrp_cmd_st_t cst_d;
  logic [7:0]   fam_q;
  logic [7:0]   idx_q;
  logic [7:0]   status_q;
  logic [7:0]   status_d;
  logic [7:0]   mode_q;
  logic [7:0]   thr_q;

  wire cmd_in   = i_cmd_valid && o_cmd_ready;
  wire is_mode  = (fam_q == `SHRP_FAM_OUT_MODE) && (idx_q == `SHRP_IDX_OUT_MODE);
  wire is_thr   = (fam_q == `SHRP_FAM_OUT_MODE) && (idx_q == `SHRP_IDX_FIFO_THR);
  wire data_in  = cmd_in && (cst_q == SHRP_C_DATA);
  wire wr_mode  = data_in && i_cmd_last && is_mode;
  wire wr_thr   = data_in && i_cmd_last && is_thr;
  wire rsp_take = o_rsp_valid && i_rsp_ready;

  assign o_cmd_ready      = (cst_q != SHRP_C_RSP0) && (cst_q != SHRP_C_RSP1);
  assign o_rsp_valid      = (cst_q == SHRP_C_RSP0) || (cst_q == SHRP_C_RSP1);
  assign o_rsp_byte       = (cst_q == SHRP_C_RSP0) ? `SHRP_RSP_START : status_q;
  assign o_output_mode    = mode_q;
  assign o_fifo_threshold = thr_q;

  always_comb
  begin
    cst_d    = cst_q;
    status_d = status_q;
    case (cst_q)
      SHRP_C_HDR:
        if (cmd_in)
        begin
          status_d = `SHRP_ST_BAD_FRAME;
          if (i_cmd_last)
            cst_d = SHRP_C_RSP0;
          else if (i_cmd_byte == `SHRP_CMD_START)
            cst_d = SHRP_C_FAM;
          else
            cst_d = SHRP_C_DRAIN;
        end
      SHRP_C_FAM:
        if (cmd_in)
          cst_d = i_cmd_last ? SHRP_C_RSP0 : SHRP_C_IDX;
      SHRP_C_IDX:
        if (cmd_in)
          cst_d = i_cmd_last ? SHRP_C_RSP0 : SHRP_C_DATA;
      SHRP_C_DATA:
        if (cmd_in)
        begin
          status_d = (is_mode || is_thr) ? `SHRP_ST_OK : `SHRP_ST_BAD_CMD;
          if (!i_cmd_last)
            status_d = `SHRP_ST_BAD_FRAME;
          cst_d = i_cmd_last ? SHRP_C_RSP0 : SHRP_C_DRAIN;
        end
      SHRP_C_DRAIN:
        if (cmd_in && i_cmd_last)
          cst_d = SHRP_C_RSP0;
      SHRP_C_RSP0:
        if (rsp_take)
          cst_d = SHRP_C_RSP1;
      SHRP_C_RSP1:
        if (rsp_take)
          cst_d = SHRP_C_HDR;
      default:
        cst_d = SHRP_C_HDR;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cst_q    <= SHRP_C_HDR;
      status_q <= `SHRP_ST_OK;
      fam_q    <= 8'h00;
      idx_q    <= 8'h00;
    end
    else if (i_clk_en)
    begin
      cst_q    <= cst_d;
      status_q <= status_d;
      if (cmd_in && cst_q == SHRP_C_FAM)
        fam_q <= i_cmd_byte;
      if (cmd_in && cst_q == SHRP_C_IDX)
        idx_q <= i_cmd_byte;
    end
  end

  // a short or malformed frame leaves both settings untouched
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      mode_q <= `SHRP_MODE_RST;
      thr_q  <= `SHRP_THR_RST;
    end
    else if (i_clk_en)
    begin
      if (wr_mode)
        mode_q <= i_cmd_byte;
      if (wr_thr)
        thr_q <= i_cmd_byte;
    end
  end

  // ==========================================================
  // checks
  a_oxy_length: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_clk_en && take_oxy |=> left_q == `SHRP_OXY_LEN)
    else $error("oxygen record length wrong");
  a_oxy_first: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_clk_en && take_oxy |=> o_fifo_data == $past(i_oxy_rec.ratio_x10[15:8]))
    else $error("oxygen record not msb first");
  a_oxy_state: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_clk_en && take_oxy |=> buf_q[23:16] == {6'h00, $past(i_oxy_rec.oxygen_algorithm_state)})
    else $error("oxygen state byte misplaced");
  a_bp_status: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_clk_en && take_bp |=> o_fifo_data == {5'h00, $past(i_bp_rec.status)} && left_q == `SHRP_BP_LEN)
    else $error("pressure status byte wrong");
  a_bp_gated: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_clk_en && take_bp && !cal_done |=> buf_q[55:40] == 16'h0000)
    else $error("pressure values leaked before calibration");
  a_bp_pulse: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_clk_en && take_bp |=> buf_q[0] == ($past(i_bp_rec.heart_rate_x10) > 16'h03b6))
    else $error("elevated pulse flag wrong");
  a_stall_hold: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    o_fifo_valid && (!i_fifo_ready || !i_clk_en) |=> o_fifo_valid && $stable(o_fifo_data))
    else $error("byte changed under back-pressure");
  a_mode_resp: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_clk_en && wr_mode |=> o_rsp_valid && o_rsp_byte == `SHRP_RSP_START && status_q == `SHRP_ST_OK)
    else $error("mode command answer wrong");
  a_thr_write: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    i_clk_en && wr_thr |=> o_fifo_threshold == $past(i_cmd_byte) && status_q == 8'h00)
    else $error("second mode command not applied");

  c_oxy_rec: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) take_oxy && i_clk_en);
  c_bp_rec: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) take_bp && i_clk_en && cal_done);
  c_mode_cmd: cover property (@(posedge i_core_clk) disable iff (!i_arst_n) wr_mode && i_clk_en);
  c_back_to_back: cover property (@(posedge i_core_clk) disable iff (!i_arst_n)
    left_q == 4'h1 && byte_out && i_clk_en ##1 take_bp && i_clk_en);
endmodule : shrp_record_packer

// file: verification/shrp_host_model.sv
`timescale 1ns/1ps
// ==========
// host side: sends command frames, reads responses and samples
module shrp_host_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_clk_en,
  input  wire logic       i_slow,
  input  wire logic       i_cmd_ready,
  input  wire logic       i_rsp_valid,
  input  wire logic [7:0] i_rsp_byte,
  input  wire logic       i_fifo_valid,
  input  wire logic [7:0] i_fifo_data,
  output logic            o_cmd_valid,
  output logic [7:0]      o_cmd_byte,
  output logic            o_cmd_last,
  output logic            o_rsp_ready,
  output logic            o_fifo_ready
);
  logic [7:0] rsp_q[$];
  logic [7:0] smp_q[$];
  logic [1:0] stall_q = 2'h0;
  initial
  begin
    o_cmd_valid  = 1'b0;
    o_cmd_byte   = 8'h5a;
    o_cmd_last   = 1'b0;
    o_rsp_ready  = 1'b1;
    o_fifo_ready = 1'b1;
  end
  // a slow reader proves bytes stand until taken
  always @(negedge i_core_clk)
  begin
    stall_q      <= stall_q + 2'h1;
    o_rsp_ready  <= !i_slow || stall_q == 2'h0;
    o_fifo_ready <= !i_slow || stall_q != 2'h1;
  end
  always @(posedge i_core_clk)
  begin
    if (i_clk_en && i_rsp_valid && o_rsp_ready)
      rsp_q.push_back(i_rsp_byte);
    if (i_clk_en && i_fifo_valid && o_fifo_ready)
      smp_q.push_back(i_fifo_data);
  end
  task automatic send_frame(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      @(negedge i_core_clk);
      o_cmd_valid = 1'b1;
      o_cmd_byte  = b[i];
      o_cmd_last  = (i == b.size() - 1);
      #1;
      while (!(i_cmd_ready && i_clk_en))
      begin
        @(negedge i_core_clk);
        #1;
      end
      @(posedge i_core_clk);
    end
    @(negedge i_core_clk);
    o_cmd_valid = 1'b0;
    o_cmd_last  = 1'b0;
    // no stale byte once the bus is released
    o_cmd_byte  = ~o_cmd_byte;
  endtask : send_frame
endmodule : shrp_host_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                    core_clk = 1'b0;
  logic                    arst_n, clk_en, slow, wobble;
  logic                    oxy_valid, oxy_ready, bp_valid, bp_ready;
  shrp_pkg::shrp_oxy_rec_t oxy_rec;
  shrp_pkg::shrp_bp_rec_t  bp_rec;
  logic                    fifo_valid, fifo_ready, cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_ready;
  logic [7:0]              fifo_data, cmd_byte, rsp_byte, out_mode, fifo_thr;
  logic [7:0]              exp_q[$];
  int                      error_cnt = 0;
  int                      checks_done = 0;
  always #2 core_clk = ~core_clk;
  always @(negedge core_clk)
    if (wobble)
      clk_en = ~clk_en;
  shrp_record_packer DUT (.i_core_clk(core_clk), .i_arst_n(arst_n), .i_clk_en(clk_en), .i_oxy_valid(oxy_valid),
    .i_oxy_rec(oxy_rec), .o_oxy_ready(oxy_ready), .i_bp_valid(bp_valid), .i_bp_rec(bp_rec), .o_bp_ready(bp_ready),
    .o_fifo_valid(fifo_valid), .o_fifo_data(fifo_data), .i_fifo_ready(fifo_ready), .i_cmd_valid(cmd_valid),
    .i_cmd_byte(cmd_byte), .i_cmd_last(cmd_last), .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid),
    .o_rsp_byte(rsp_byte), .i_rsp_ready(rsp_ready), .o_output_mode(out_mode), .o_fifo_threshold(fifo_thr));
  shrp_host_model host (.i_core_clk(core_clk), .i_clk_en(clk_en), .i_slow(slow), .i_cmd_ready(cmd_ready),
    .i_rsp_valid(rsp_valid), .i_rsp_byte(rsp_byte), .i_fifo_valid(fifo_valid), .i_fifo_data(fifo_data),
    .o_cmd_valid(cmd_valid), .o_cmd_byte(cmd_byte), .o_cmd_last(cmd_last), .o_rsp_ready(rsp_ready),
    .o_fifo_ready(fifo_ready));
  // ==========
  // checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict
  initial
  begin
    #40000;
    error_cnt++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    give_verdict();
  end
  // ==========
  // stimulus helpers
  task automatic cmd(input logic [7:0] b[$], input logic [7:0] st);
    host.rsp_q.delete();
    host.send_frame(b);
    repeat (40)
      if (host.rsp_q.size() < 2)
        @(negedge core_clk);
    check(host.rsp_q[0], 8'hab);
    check(host.rsp_q[1], st);
  endtask : cmd
  task automatic put_oxy(input logic [1:0] st);
    oxy_rec = '{16'h1230 + st, 8'h63, 16'h03e0, 8'h50, st[0], st[1], shrp_pkg::shrp_oxy_state_t'(st)};
    exp_q = {exp_q, 8'h12, 8'h30 + st, 8'h63, 8'h03, 8'he0, 8'h50, 8'(st[0]), 8'(st[1]), 8'(st)};
  endtask : put_oxy
  task automatic put_bp(input logic [2:0] st, input logic [7:0] cal, input logic [15:0] hr);
    bp_rec = '{st, cal, hr, 8'h78, 8'h4f, 16'h03c5, 16'h0203};
    exp_q = {exp_q, 8'(st), cal, hr[15:8], hr[7:0], (cal == 8'h64) ? 8'h78 : 8'h00,
             (cal == 8'h64) ? 8'h4f : 8'h00, 8'h03, 8'hc5, 8'h02, 8'h03, 8'(hr > 16'h03b6)};
  endtask : put_bp
  task automatic offer(input logic ox, input logic bp);
    logic take_o, take_b;
    @(negedge core_clk);
    oxy_valid = ox;
    bp_valid  = bp;
    while (oxy_valid || bp_valid)
    begin
      #1;
      take_o = oxy_valid && oxy_ready && clk_en;
      take_b = bp_valid && bp_ready && clk_en;
      @(negedge core_clk);
      if (take_o)
        {oxy_valid, oxy_rec} = {1'b0, ~oxy_rec};
      if (take_b)
        {bp_valid, bp_rec} = {1'b0, ~bp_rec};
    end
  endtask : offer
  task automatic drain(input string name);
    repeat (600)
      if (host.smp_q.size() < exp_q.size())
        @(negedge core_clk);
    check(16'(host.smp_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
      check(host.smp_q[i], exp_q[i]);
    host.smp_q.delete();
    exp_q.delete();
    $display("test %s done", name);
  endtask : drain
  // ==========
  // tests
  initial
  begin
    {arst_n, oxy_valid, bp_valid, slow, wobble, oxy_rec, bp_rec} = '0;
    clk_en = 1'b1;
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    put_oxy(2'h1);
    exp_q.delete();
    oxy_valid = 1'b1;
    repeat (4) @(negedge core_clk);
    check(oxy_ready, 1'b0);
    oxy_valid = 1'b0;
    check(out_mode, 8'h00);
    drain("refused before mode");
    cmd('{8'haa, 8'h10, 8'h00, 8'h03}, 8'h00);
    check(out_mode, 8'h03);
    cmd('{8'haa, 8'h10, 8'h01, 8'h0f}, 8'h00);
    check(fifo_thr, 8'h0f);
    slow = 1'b1;
    cmd('{8'haa, 8'h11, 8'h00, 8'h05}, 8'h02);
    cmd('{8'haa, 8'h10, 8'h00}, 8'h03);
    cmd('{8'haa, 8'h10, 8'h00, 8'h07, 8'h01}, 8'h03);
    cmd('{8'hbb, 8'h10, 8'h00, 8'h00}, 8'h03);
    check(out_mode, 8'h03);
    $display("test commands done");
    for (int s = 0; s < 4; s++)
    begin
      put_oxy(2'(s));
      offer(1'b1, 1'b0);
    end
    drain("oxygen records");
    wobble = 1'b1;
    for (int s = 0; s < 7; s++)
    begin
      put_bp(3'(s), s[0] ? 8'h64 : 8'h63, 16'h03b5 + 16'(s));
      offer(1'b0, 1'b1);
    end
    wobble = 1'b0;
    @(negedge core_clk);
    clk_en = 1'b1;
    drain("pressure records");
    put_oxy(2'h3);
    put_bp(3'h6, 8'h64, 16'h0400);
    offer(1'b1, 1'b1);
    drain("simultaneous records");
    give_verdict();
  end
endmodule : tb_top
